/* rtl/cmp_ctrl.sv */
// Mode sequencer and protection logic of the battery charger.
// Assumes register strobes come from the serial bus front end on
// ref_clk and all pin and comparator levels are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_regs.svh"

module cmp_ctrl #(
    parameter int unsigned QUAL_CYCLES = `CMP_QUAL_MS * `CMP_CLK_KHZ,
    parameter int unsigned SEC_CYCLES  = `CMP_SEC_MS * `CMP_CLK_KHZ
) (
    input  wire logic       ref_clk,           // 125 MHz clock
    input  wire logic       rst,               // Async reset
    input  wire logic       vin_ok,            // Input supply present
    input  wire logic       storage_mode_pin,  // Storage pin level
    input  wire logic       charge_enable_pin, // Comparator above 0.8V
    input  wire logic       reverse_supply_request_n, // Low requests
    input  wire logic       tj_over_shut,      // Junction above trip
    input  wire logic       tj_below_restart,  // Junction below restart
    input  wire logic       switch_over_limit, // Any switch over limit
    input  wire logic       switch_cycle_start, // Switching cycle edge
    input  wire logic       bat_above_dead,    // Above deep discharge
    input  wire logic       bat_above_short,   // Above shorted cell
    input  wire logic       bat_above_pre,     // Above precharge exit
    input  wire logic       bat_above_term,    // Above termination
    input  wire logic       reg_wr,            // Register write strobe
    input  wire logic       reg_rd,            // Register read strobe
    input  wire logic [7:0] reg_addr,          // Register offset
    input  wire logic [7:0] reg_wdata,         // Write data
    output logic      [7:0] reg_rdata_q,       // Read data
    output logic      [2:0] mode_q,            // Current mode
    output logic            converter_en_q,    // Converter may switch
    output logic            switch_block_q,    // Switch off this cycle
    output logic            switch_current_threshold_sel_q, // 10A
    output logic      [2:0] charge_phase_q,    // Charge phase
    output logic      [6:0] applied_scale_q,   // Applied percent
    output logic            dead_current_en_q  // Fixed 10mA source on
);

    localparam logic [22:0] QUAL_N = QUAL_CYCLES[22:0];
    localparam logic [26:0] SEC_N  = SEC_CYCLES[26:0];

    // ****************************************
    // Decode helpers
    // ****************************************
    // Timeout in seconds for a select code, zero means off
    function automatic logic [8:0] ka_limit(input logic [1:0] sel);
        case (sel)
            2'h1:    ka_limit = `CMP_KA_T1_S;
            2'h2:    ka_limit = `CMP_KA_T2_S;
            2'h3:    ka_limit = `CMP_KA_T3_S;
            default: ka_limit = 9'h000;
        endcase
    endfunction : ka_limit

    // Write or read strobe for one offset
    function automatic logic hit(input logic s, input logic [7:0] a,
                                 input logic [7:0] off);
        hit = s && (a == off);
    endfunction : hit

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [11:0] pins_s;
    cmp_sync #(.W(12)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({vin_ok, storage_mode_pin, charge_enable_pin,
                    reverse_supply_request_n, tj_over_shut,
                    tj_below_restart, switch_over_limit,
                    switch_cycle_start, bat_above_dead,
                    bat_above_short, bat_above_pre, bat_above_term}),
        .sync_q   (pins_s)
    );

    logic vin_s, stor_s, en_s, rev_n_s, hot_s, cool_s, trip_s, cyc_s;
    logic dead_s, short_s, pre_s, term_s;
    assign {vin_s, stor_s, en_s, rev_n_s, hot_s, cool_s, trip_s, cyc_s,
            dead_s, short_s, pre_s, term_s} = pins_s;

    // ****************************************
    // Register file
    // ****************************************
    logic       park_q, park_d, force_q, force_d, ilim_q, ilim_d;
    logic       ocpdis_q, ocpdis_d, kick;
    logic [1:0] ka_sel_q, ka_sel_d, short_q, short_d;
    logic [3:0] pre_q, pre_d;
    logic [6:0] scale_q, scale_d;
    logic       wr_mode, wr_prot, rd_mode;

    assign wr_mode = hit(reg_wr, reg_addr, `CMP_REG_MODE);
    assign wr_prot = hit(reg_wr, reg_addr, `CMP_REG_PROT);
    assign rd_mode = hit(reg_rd, reg_addr, `CMP_REG_MODE);
    assign kick    = wr_mode && reg_wdata[`CMP_MODE_KICK];

    // Next values of software-written fields
    always_comb begin
        park_d   = park_q;
        force_d  = force_q;
        ilim_d   = ilim_q;
        ocpdis_d = ocpdis_q;
        ka_sel_d = ka_sel_q;
        short_d  = short_q;
        pre_d    = pre_q;
        scale_d  = scale_q;
        if (wr_mode) begin
            park_d  = reg_wdata[`CMP_MODE_PARK];
            force_d = reg_wdata[`CMP_MODE_FORCE];
        end
        if (wr_prot) begin
            ilim_d   = reg_wdata[`CMP_PROT_ILIM];
            ocpdis_d = reg_wdata[`CMP_PROT_OCPDIS];
            ka_sel_d = reg_wdata[`CMP_PROT_KA_LSB +: 2];
        end
        if (hit(reg_wr, reg_addr, `CMP_REG_SHORT)) begin
            short_d = reg_wdata[1:0];
        end
        if (hit(reg_wr, reg_addr, `CMP_REG_PRE)) begin
            pre_d = reg_wdata[3:0];
        end
        if (hit(reg_wr, reg_addr, `CMP_REG_SCALE)) begin
            scale_d = reg_wdata[6:0];
        end
    end

    // Register the fields
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            park_q   <= `CMP_PARK_RST;
            force_q  <= `CMP_FORCE_RST;
            ilim_q   <= `CMP_ILIM_RST;
            ocpdis_q <= `CMP_OCPDIS_RST;
            ka_sel_q <= `CMP_KA_SEL_RST;
            short_q  <= `CMP_SHORT_RST;
            pre_q    <= `CMP_PRE_RST;
            scale_q  <= `CMP_SCALE_RST;
        end else begin
            park_q   <= park_d;
            force_q  <= force_d;
            ilim_q   <= ilim_d;
            ocpdis_q <= ocpdis_d;
            ka_sel_q <= ka_sel_d;
            short_q  <= short_d;
            pre_q    <= pre_d;
            scale_q  <= scale_d;
        end
    end

    // ****************************************
    // Storage qualification counter
    // ****************************************
    cmp_pkg::cmp_mode_t st_q, st_d;
    logic [22:0] qual_q, qual_d;
    logic        qual_cond, qual_done;

    // Exit needs supply or pin low; re-entry needs pin high, no supply
    always_comb begin
        if (st_q == cmp_pkg::CMP_STORAGE) begin
            qual_cond = vin_s || !stor_s;
        end else begin
            qual_cond = stor_s && !vin_s;
        end
        qual_done = qual_cond && (qual_q == QUAL_N);
        if (!qual_cond || qual_done) begin
            qual_d = 23'h000000;
        end else begin
            qual_d = qual_q + 23'h000001;
        end
    end

    // Register the count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            qual_q <= 23'h000000;
        end else begin
            qual_q <= qual_d;
        end
    end

    // ****************************************
    // Keepalive timer
    // ****************************************
    logic [26:0] tick_q, tick_d;
    logic [8:0]  ka_q, ka_d;
    logic        ka_run, ka_expired;

    assign ka_run = (st_q == cmp_pkg::CMP_CHARGE) ||
                    (st_q == cmp_pkg::CMP_REVERSE);
    assign ka_expired = ka_run && (ka_limit(ka_sel_q) != 9'h000) &&
                        (ka_q >= ka_limit(ka_sel_q));

    // Seconds prescaler and seconds count
    always_comb begin
        tick_d = tick_q + 27'h0000001;
        ka_d   = ka_q;
        if (!ka_run || kick || ka_limit(ka_sel_q) == 9'h000) begin
            tick_d = 27'h0000000;
            ka_d   = 9'h000;
        end else if (tick_q == SEC_N - 27'h0000001) begin
            tick_d = 27'h0000000;
            if (!ka_expired) begin
                ka_d = ka_q + 9'h001;
            end
        end
    end

    // Register the timer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_q <= 27'h0000000;
            ka_q   <= 9'h000;
        end else begin
            tick_q <= tick_d;
            ka_q   <= ka_d;
        end
    end

    // ****************************************
    // Mode state machine
    // ****************************************
    logic chg_req, rev_req;
    assign chg_req = force_q || en_s;
    assign rev_req = !rev_n_s;

    // Next mode
    always_comb begin
        st_d = st_q;
        case (st_q)
            cmp_pkg::CMP_STORAGE: begin
                if (qual_done) st_d = cmp_pkg::CMP_PARK;
            end
            cmp_pkg::CMP_PARK: begin
                if (qual_done) begin
                    st_d = cmp_pkg::CMP_STORAGE;
                end else if (park_q) begin
                    st_d = cmp_pkg::CMP_PARK;
                end else if (rev_req) begin
                    st_d = cmp_pkg::CMP_REVERSE;
                end else if (chg_req) begin
                    st_d = cmp_pkg::CMP_CHARGE;
                end
            end
            cmp_pkg::CMP_CHARGE: begin
                if (qual_done) begin
                    st_d = cmp_pkg::CMP_STORAGE;
                end else if (park_q || !chg_req) begin
                    st_d = cmp_pkg::CMP_PARK;
                end else if (ka_expired) begin
                    st_d = cmp_pkg::CMP_FAULT;
                end
            end
            cmp_pkg::CMP_REVERSE: begin
                if (qual_done) begin
                    st_d = cmp_pkg::CMP_STORAGE;
                end else if (park_q || !rev_req) begin
                    st_d = cmp_pkg::CMP_PARK;
                end else if (ka_expired) begin
                    st_d = cmp_pkg::CMP_FAULT;
                end
            end
            cmp_pkg::CMP_FAULT: begin
                if (park_q || (!chg_req && !rev_req)) begin
                    st_d = cmp_pkg::CMP_PARK;
                end
            end
            default: st_d = cmp_pkg::CMP_STORAGE;
        endcase
    end

    // Register the mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= cmp_pkg::CMP_STORAGE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Thermal and switch current protection
    // ****************************************
    logic       hot_q, hot_d, ovt_q, ovt_d, ocp_q, ocp_d;
    logic       blk_d, seen_q, seen_d, cyc_q, cyc_edge;
    logic [3:0] trips_q, trips_d;

    assign cyc_edge = cyc_s && !cyc_q;

    // Fault latches and cycle trip counting
    always_comb begin
        hot_d = hot_q;
        if (hot_s) begin
            hot_d = 1'b1;
        end else if (cool_s) begin
            hot_d = 1'b0;
        end
        // Read clears, a new event in the same cycle wins
        ovt_d = (ovt_q && !rd_mode) || hot_s;
        blk_d = trip_s || (switch_block_q && !cyc_edge);
        seen_d  = seen_q;
        trips_d = trips_q;
        if (cyc_edge) begin
            seen_d  = trip_s;
            trips_d = seen_q ? trips_q + 4'h1 : 4'h0;
        end else if (trip_s) begin
            seen_d = 1'b1;
        end
        if (!ka_run) begin
            trips_d = 4'h0;
        end
        ocp_d = !ocpdis_q && (st_q != cmp_pkg::CMP_PARK) &&
                (ocp_q || (ka_run && trips_d == `CMP_OCP_TRIPS));
    end

    // Register protection state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hot_q          <= 1'b0;
            ovt_q          <= 1'b0;
            ocp_q          <= 1'b0;
            switch_block_q <= 1'b0;
            seen_q         <= 1'b0;
            cyc_q          <= 1'b0;
            trips_q        <= 4'h0;
        end else begin
            hot_q          <= hot_d;
            ovt_q          <= ovt_d;
            ocp_q          <= ocp_d;
            switch_block_q <= blk_d;
            seen_q         <= seen_d;
            cyc_q          <= cyc_s;
            trips_q        <= trips_d;
        end
    end

    // ****************************************
    // Charge phase and current scale
    // ****************************************
    cmp_pkg::cmp_phase_t ph_d;
    logic [6:0]          scl_d;

    // Phase from battery comparators, then percent for that phase
    always_comb begin
        if (term_s)       ph_d = cmp_pkg::CMP_PH_DONE;
        else if (pre_s)   ph_d = cmp_pkg::CMP_PH_FAST;
        else if (short_s) ph_d = cmp_pkg::CMP_PH_PRE;
        else if (dead_s)  ph_d = cmp_pkg::CMP_PH_SHORT;
        else              ph_d = cmp_pkg::CMP_PH_DEAD;
        case (ph_d)
            cmp_pkg::CMP_PH_SHORT: scl_d = 7'h01 << short_q;
            cmp_pkg::CMP_PH_PRE:   scl_d = `CMP_PRE_BASE + {3'h0, pre_q};
            cmp_pkg::CMP_PH_FAST: begin
                if (scale_q == 7'h00)             scl_d = `CMP_SCALE_MIN;
                else if (scale_q > `CMP_SCALE_MAX) scl_d = `CMP_SCALE_MAX;
                else                              scl_d = scale_q;
            end
            default: scl_d = 7'h00;
        endcase
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q                         <= 3'h0;
            converter_en_q                 <= 1'b0;
            switch_current_threshold_sel_q <= 1'b0;
            charge_phase_q                 <= 3'h0;
            applied_scale_q                <= 7'h00;
            dead_current_en_q              <= 1'b0;
            reg_rdata_q                    <= 8'h00;
        end else begin
            mode_q <= st_d;
            converter_en_q <= (st_d == cmp_pkg::CMP_CHARGE ||
                               st_d == cmp_pkg::CMP_REVERSE) &&
                              !hot_d && !ocp_d;
            switch_current_threshold_sel_q <= ilim_d;
            charge_phase_q <= ph_d;
            applied_scale_q <= scl_d;
            dead_current_en_q <= (st_d == cmp_pkg::CMP_CHARGE) &&
                                 (ph_d == cmp_pkg::CMP_PH_DEAD);
            case (reg_addr)
                `CMP_REG_MODE:  reg_rdata_q <= {st_q, ocp_q, ovt_q, 1'b0,
                                                force_q, park_q};
                `CMP_REG_PROT:  reg_rdata_q <= {4'h0, ka_sel_q, ocpdis_q,
                                                ilim_q};
                `CMP_REG_SHORT: reg_rdata_q <= {6'h00, short_q};
                `CMP_REG_SCALE: reg_rdata_q <= {1'b0, scale_q};
                `CMP_REG_PRE:   reg_rdata_q <= {4'h0, pre_q};
                default:        reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_ovt_stops_conv: assert property (hot_s |=> !converter_en_q)
        else $error("Converter on during over-temperature");
    a_ovt_sticky: assert property (ovt_q && !rd_mode |=> ovt_q)
        else $error("Over-temperature bit lost without read");
    a_park_hold: assert property ((st_q == cmp_pkg::CMP_PARK) && park_q
        && !qual_done |=> st_q == cmp_pkg::CMP_PARK)
        else $error("Left park with park bit set");
    a_charge_entry: assert property ((st_q == cmp_pkg::CMP_CHARGE) &&
        ($past(st_q) != cmp_pkg::CMP_CHARGE) |->
        $past(st_q) == cmp_pkg::CMP_PARK)
        else $error("Charge entered from other than park");
    a_reverse_wins: assert property ((st_q == cmp_pkg::CMP_PARK) &&
        !park_q && !qual_done && rev_req && chg_req |=>
        st_q == cmp_pkg::CMP_REVERSE)
        else $error("Reverse supply did not win");
    a_ocp_eight: assert property (ka_run && !ocpdis_q && cyc_edge &&
        seen_q && trips_q == 4'h7 |=> ocp_q ##1 !converter_en_q)
        else $error("Eight trips did not latch off");
    a_ocp_disable: assert property (ocpdis_q |=> !ocp_q)
        else $error("Latch held with disable bit set");
    a_ka_park_zero: assert property (st_q == cmp_pkg::CMP_PARK |=>
        ka_q == 9'h000)
        else $error("Keepalive not zero in park");
    a_ka_kick: assert property (kick |=> ka_q == 9'h000 && tick_q == 0)
        else $error("Keepalive write did not restart timer");
    a_sw_block: assert property (trip_s |=> switch_block_q[*1])
        else $error("Switch not blocked after trip");
    a_scale_clamp: assert property ($stable(scale_q) &&
        charge_phase_q == cmp_pkg::CMP_PH_FAST && scale_q > 7'h64 |->
        applied_scale_q == 7'h64)
        else $error("Scale above 100 not clamped");

    c_charge: cover property (st_q == cmp_pkg::CMP_CHARGE);
    c_reverse: cover property (st_q == cmp_pkg::CMP_REVERSE);
    c_fault: cover property (st_q == cmp_pkg::CMP_FAULT);
    c_ocp: cover property (ocp_q);

endmodule : cmp_ctrl

`default_nettype wire

/* rtl/cmp_regs.svh */
// Register offsets, field positions, reset values and timing constants
// for the charger mode and protection controller.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CMP_REG_MODE      8'h00
`define CMP_REG_PROT      8'h01
`define CMP_REG_SHORT     8'h0b
`define CMP_REG_SCALE     8'h18
`define CMP_REG_PRE       8'h19

// ****************************************
// Field positions
// ****************************************
`define CMP_MODE_PARK     0
`define CMP_MODE_FORCE    1
`define CMP_MODE_KICK     2
`define CMP_MODE_OVT      3
`define CMP_MODE_OCP      4
`define CMP_MODE_ST_LSB   5
`define CMP_PROT_ILIM     0
`define CMP_PROT_OCPDIS   1
`define CMP_PROT_KA_LSB   2

// ****************************************
// Reset values
// ****************************************
`define CMP_PARK_RST      1'b0
`define CMP_FORCE_RST     1'b0
`define CMP_ILIM_RST      1'b0
`define CMP_OCPDIS_RST    1'b0
`define CMP_KA_SEL_RST    2'h0
`define CMP_SCALE_RST     7'h64
`define CMP_SHORT_RST     2'h0
`define CMP_PRE_RST       4'h0

// ****************************************
// Timing and current figures
// ****************************************
`define CMP_CLK_KHZ       125000
`define CMP_QUAL_MS       32
`define CMP_SEC_MS        1000
`define CMP_KA_T1_S       9'd80
`define CMP_KA_T2_S       9'd160
`define CMP_KA_T3_S       9'd320
`define CMP_OCP_TRIPS     4'h8
`define CMP_SCALE_MIN     7'h01
`define CMP_SCALE_MAX     7'h64
`define CMP_PRE_BASE      7'h05

`endif

/* rtl/cmp_pkg.sv */
// Types shared by the charger mode and protection controller.
// Assumes nothing of its surroundings.
package cmp_pkg;

    // Operating modes of the mode state machine
    typedef enum logic [2:0] {
        CMP_STORAGE = 3'b000,
        CMP_PARK    = 3'b001,
        CMP_CHARGE  = 3'b010,
        CMP_REVERSE = 3'b011,
        CMP_FAULT   = 3'b100
    } cmp_mode_t;

    // Charge current phases from battery voltage
    typedef enum logic [2:0] {
        CMP_PH_DEAD  = 3'b000,
        CMP_PH_SHORT = 3'b001,
        CMP_PH_PRE   = 3'b010,
        CMP_PH_FAST  = 3'b011,
        CMP_PH_DONE  = 3'b100
    } cmp_phase_t;

endpackage : cmp_pkg

/* rtl/cmp_sync.sv */
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no word coherence is kept.
`timescale 1ns/1ps
`default_nettype none

module cmp_sync #(
    parameter int W = 12
) (
    input  wire logic         ref_clk, // Clock
    input  wire logic         rst,     // Async reset, active high
    input  wire logic [W-1:0] async_in, // Levels from outside
    output logic      [W-1:0] sync_q    // Synchronised levels
);

    // ****************************************
    // Synchroniser stages
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            // First stage is read only by the second
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta_q    <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q    <= async_in[i];
                    sync_q[i] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : cmp_sync

`default_nettype wire

/* tb/cmp_host.sv */
// Host model: drives the register port of the charger controller.
// Assumes the bench calls one task at a time, away from reset.
`timescale 1ns/1ps
`default_nettype none
module cmp_host (
    input  wire logic       ref_clk,     // Clock
    input  wire logic [7:0] reg_rdata_q, // Read data
    output logic            reg_wr,      // Write strobe
    output logic            reg_rd,      // Read strobe
    output logic      [7:0] reg_addr,    // Offset
    output logic      [7:0] reg_wdata    // Write data
);
    // Idle port from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h02;
        reg_wdata = 8'h00;
    end
    // One-cycle write strobe, held across a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr
    // Read strobe; data is registered at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        v = reg_rdata_q;
        reg_rd = 1'b0;
    endtask : rd
    // Periodic keepalive write from the host side
    task automatic kick();
        wr(8'h00, 8'h04);
    endtask : kick
endmodule : cmp_host
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the charger mode and protection controller.
// Assumes cmp_ctrl built with short qualify and second counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       ref_clk = 1'b0, rst = 1'b1, vin = 1'b0, cen = 1'b0;
    logic       rvn = 1'b1, tov = 1'b0, tbr = 1'b1;
    logic [3:0] bat = 4'h7;
    logic       stp = 1'b1, sol = 1'b0, scs = 1'b0, blk, thr, dce;
    logic       wr, rd, cen_q;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] mode, ph;
    logic [6:0] scale;
    int         bad_count = 0, total_checks = 0, cyc = 0;
    // Clock and hang guard
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            test_done();
        end
    end
    cmp_ctrl #(.QUAL_CYCLES(20), .SEC_CYCLES(10)) cmp_ctrl_inst (
        .ref_clk(ref_clk), .rst(rst), .vin_ok(vin),
        .storage_mode_pin(stp), .charge_enable_pin(cen),
        .reverse_supply_request_n(rvn), .tj_over_shut(tov),
        .tj_below_restart(tbr), .switch_over_limit(sol),
        .switch_cycle_start(scs), .bat_above_dead(bat[0]),
        .bat_above_short(bat[1]), .bat_above_pre(bat[2]),
        .bat_above_term(bat[3]), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata),
        .mode_q(mode), .converter_en_q(cen_q),
        .switch_block_q(blk), .switch_current_threshold_sel_q(thr),
        .charge_phase_q(ph), .applied_scale_q(scale),
        .dead_current_en_q(dce));
    cmp_host cmp_host_inst (.ref_clk(ref_clk), .reg_rdata_q(rdata),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : w
    // Switching cycles, each with or without a current trip
    task automatic sw(input int n, input logic t);
        repeat (n) begin
            scs = 1'b1;
            sol = t;
            w(3);
            scs = 1'b0;
            sol = 1'b0;
            w(3);
        end
    endtask : sw
    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Test sequence
    initial begin
        w(12);
        rst = 1'b0;
        chk({5'h00, mode}, 8'h00);
        vin = 1'b1;
        w(40);
        chk({5'h00, mode}, 8'h01);
        $display("test storage exit done");
        rvn = 1'b0;
        cen = 1'b1;
        w(8);
        chk({5'h00, mode}, 8'h03);
        rvn = 1'b1;
        w(8);
        chk({5'h00, mode}, 8'h02);
        rvn = 1'b0;
        w(8);
        chk({5'h00, mode}, 8'h02);
        rvn = 1'b1;
        $display("test mode sequence done");
        chk({5'h00, ph}, 8'h03);
        cmp_host_inst.wr(8'h18, 8'h00);
        w(3);
        chk({1'b0, scale}, 8'h01);
        cmp_host_inst.wr(8'h18, 8'h4b);
        w(3);
        chk({1'b0, scale}, 8'h4b);
        cmp_host_inst.wr(8'h18, 8'h7f);
        w(3);
        chk({1'b0, scale}, 8'h64);
        cmp_host_inst.rd(8'h18, d);
        chk(d, 8'h7f);
        bat = 4'h0;
        w(4);
        chk({dce, scale}, 8'h80);
        cmp_host_inst.wr(8'h0b, 8'h03);
        bat = 4'h1;
        w(4);
        chk({dce, scale}, 8'h08);
        cmp_host_inst.wr(8'h19, 8'h0f);
        bat = 4'h3;
        w(4);
        chk({dce, scale}, 8'h14);
        bat = 4'hf;
        w(4);
        chk({5'h00, ph}, 8'h04);
        chk({dce, scale}, 8'h00);
        bat = 4'h7;
        $display("test scale done");
        tov = 1'b1;
        tbr = 1'b0;
        w(5);
        chk({7'h00, cen_q}, 8'h00);
        tov = 1'b0;
        tbr = 1'b1;
        w(5);
        chk({7'h00, cen_q}, 8'h01);
        cmp_host_inst.rd(8'h00, d);
        chk(d & 8'h08, 8'h08);
        cmp_host_inst.rd(8'h00, d);
        chk(d & 8'h08, 8'h00);
        $display("test overtemp done");
        cmp_host_inst.wr(8'h01, 8'h04);
        cmp_host_inst.kick();
        w(700);
        cmp_host_inst.kick();
        w(700);
        chk({5'h00, mode}, 8'h02);
        w(200);
        chk({5'h00, mode}, 8'h04);
        chk({7'h00, cen_q}, 8'h00);
        cmp_host_inst.wr(8'h00, 8'h01);
        w(4);
        chk({5'h00, mode}, 8'h01);
        $display("test keepalive done");
        cmp_host_inst.wr(8'h01, 8'h01);
        cmp_host_inst.wr(8'h00, 8'h00);
        w(4);
        chk({6'h00, thr, cen_q}, 8'h03);
        sw(1, 1'b1);
        chk({7'h00, blk}, 8'h01);
        sw(7, 1'b1);
        sw(1, 1'b0);
        chk({7'h00, cen_q}, 8'h00);
        cmp_host_inst.rd(8'h00, d);
        chk(d & 8'h10, 8'h10);
        cen = 1'b0;
        w(6);
        cen = 1'b1;
        w(6);
        chk({7'h00, cen_q}, 8'h01);
        cmp_host_inst.wr(8'h01, 8'h03);
        sw(8, 1'b1);
        sw(1, 1'b0);
        chk({6'h00, blk, cen_q}, 8'h01);
        $display("test overcurrent done");
        cen = 1'b0;
        rst = 1'b1;
        vin = 1'b0;
        stp = 1'b0;
        w(2);
        rst = 1'b0;
        chk({5'h00, mode}, 8'h00);
        w(40);
        chk({5'h00, mode}, 8'h01);
        $display("test storage pin exit done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
